// ==== design/rofd_force_disarm.sv ====
// relay output force and disarm control between normal drive and contacts
// assumes pin inputs are asynchronous and the register port is on i_core_clk
`timescale 1ns/1ps
`default_nettype none
module rofd_force_disarm #(
  parameter int unsigned P_TICK_CYC = rofd_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset_n,
  // register port
  input  wire logic [rofd_pkg::AW-1:0] i_addr,
  input  wire logic [31:0]             i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [31:0]             o_rdata,
  // contact inputs
  input  wire logic [rofd_pkg::NC-1:0] i_normal_drive,
  input  wire logic [rofd_pkg::NC-1:0] i_force_permit,
  input  wire logic [rofd_pkg::NC-1:0] i_latched,
  input  wire logic [rofd_pkg::NC-1:0] i_hold_run,
  input  wire logic [rofd_pkg::NG-1:0] i_disarm_cmd,
  input  wire logic                    i_zone_drive,
  input  wire logic                    i_supv_drive,
  // contact outputs
  output logic      [rofd_pkg::NC-1:0] o_contact,
  output logic                         o_zone_out,
  output logic                         o_supv_out
);
  import rofd_pkg::*;

  typedef struct packed {
    logic [PW-1:0]  s1;
    logic [PW-1:0]  s2;
    logic [NC-1:0]  sf_en;
    logic [NC-1:0]  sf_pos;
    logic [NC-1:0]  out;
    logic [NG-1:0]  gf_en;
    logic [NG-1:0]  gf_pos;
    logic [NG-1:0]  dis_req;
    logic [3:0]     mode;
    logic [TW-1:0]  tmo;
    logic           sf_act;
    logic           gf_act;
    logic           dis_act;
    logic           tick;
    logic [TCW-1:0] tcnt;
    logic [1:0]     zs;
    logic [31:0]    rdata;
  } rofd_st_t;

  rofd_st_t s_r;
  rofd_st_t s_nxt;

  // widen a per-group vector to one bit per contact
  function automatic logic [NC-1:0] grp_spread(input logic [NG-1:0] v);
    logic [NC-1:0] r;
    r = '0;
    for (int i = 0; i < NC; i++) begin
      r[i] = v[i / GS];
    end
    return r;
  endfunction

  logic [NC-1:0] drv;
  logic [NC-1:0] perm;
  logic [NC-1:0] lat;
  logic [NC-1:0] hold;
  logic [NC-1:0] dcmd_c;
  logic [NC-1:0] dis_c;
  logic [NC-1:0] gf_c;
  logic [NC-1:0] sf_c;
  logic [NC-1:0] gpos_c;
  logic [NC-1:0] dreq_c;
  logic [NC-1:0] out_nxt;
  logic [NT-1:0] t_wr;
  logic [NT-1:0] t_any;
  logic [NT-1:0] t_exp;
  logic [NT-1:0] t_run;

  assign drv  = s_r.s2[P_DRV +: NC];
  assign perm = s_r.s2[P_PERM +: NC];
  assign lat  = s_r.s2[P_LAT +: NC];
  assign hold = s_r.s2[P_HOLD +: NC];
  assign dcmd_c = grp_spread(s_r.s2[P_DCMD +: NG]);
  assign dreq_c = grp_spread(s_r.dis_req);

  // disarm per contact, group wide
  assign dis_c = {NC{s_r.dis_act & s_r.mode[M_DCTL]}}
               & dreq_c & dcmd_c
               & ~lat & ~hold;

  // group force wins over single force
  assign gf_c = {NC{s_r.gf_act}} & grp_spread(s_r.gf_en)
              & perm & ~dis_c;
  assign sf_c = {NC{s_r.sf_act}} & s_r.sf_en & perm & ~dis_c
              & ~gf_c;
  assign gpos_c = grp_spread(s_r.gf_pos);

  // disarmed contacts keep their state
  assign out_nxt = (dis_c & s_r.out)
                 | (gf_c & gpos_c) | (sf_c & s_r.sf_pos)
                 | (~dis_c & ~gf_c & ~sf_c & drv);

  // timer triggers
  assign t_wr[T_SF]   = i_wr && (i_addr == A_SF_EN);
  assign t_wr[T_GF]   = i_wr && (i_addr == A_GF_EN);
  assign t_wr[T_DIS]  = i_wr && (i_addr == A_DIS);
  assign t_any[T_SF]  = |i_wdata[NC-1:0];
  assign t_any[T_GF]  = |i_wdata[NG-1:0];
  assign t_any[T_DIS] = |i_wdata[NG-1:0];

  for (genvar k = 0; k < NT; k++) begin : g_tmr
    rofd_timer u_tmr (
      .i_core_clk (i_core_clk),
      .i_reset_n  (i_reset_n),
      .i_start    (t_wr[k] && t_any[k]),
      .i_stop     (t_wr[k] && !t_any[k]),
      .i_tick     (s_r.tick),
      .i_load     (s_r.tmo),
      .o_run      (t_run[k]),
      .o_expire   (t_exp[k])
    );
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = {i_supv_drive, i_zone_drive, i_disarm_cmd, i_hold_run,
                i_latched, i_force_permit, i_normal_drive};
    s_nxt.s2 = s_r.s1;
    // timebase tick
    s_nxt.tick = 1'b0;
    if (s_r.tcnt >= TCW'(P_TICK_CYC - 1)) begin
      s_nxt.tcnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tcnt = s_r.tcnt + 1'b1;
    end
    // register writes
    if (i_wr) begin
      case (i_addr)
        A_SF_EN:  s_nxt.sf_en   = i_wdata[NC-1:0];
        A_SF_POS: s_nxt.sf_pos  = i_wdata[NC-1:0];
        A_GF_EN:  s_nxt.gf_en   = i_wdata[NG-1:0];
        A_GF_POS: s_nxt.gf_pos  = i_wdata[NG-1:0];
        A_DIS:    s_nxt.dis_req = i_wdata[NG-1:0];
        A_MODE:   s_nxt.mode    = i_wdata[3:0];
        A_TMO:    s_nxt.tmo     = i_wdata[TW-1:0];
        default:  s_nxt.mode    = s_r.mode;
      endcase
    end
    // active flags: a write beats a same-cycle expiry
    if (t_wr[T_SF]) begin
      s_nxt.sf_act = t_any[T_SF];
    end else if (t_exp[T_SF] && !s_r.mode[M_SF_PERM]) begin
      s_nxt.sf_act = 1'b0;
    end
    if (t_wr[T_GF]) begin
      s_nxt.gf_act = t_any[T_GF];
    end else if (t_exp[T_GF] && !s_r.mode[M_GF_PERM]) begin
      s_nxt.gf_act = 1'b0;
    end
    if (t_wr[T_DIS]) begin
      s_nxt.dis_act = t_any[T_DIS];
    end else if (t_exp[T_DIS] && !s_r.mode[M_DIS_PERM]) begin
      s_nxt.dis_act = 1'b0;
    end
    s_nxt.out = out_nxt;
    // zone and supervision bypass disarm and force
    s_nxt.zs = {s_r.s2[P_ZONE], s_r.s2[P_SUPV]};
    // register reads, data in the next cycle
    s_nxt.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        A_SF_EN:  s_nxt.rdata[NC-1:0] = s_r.sf_en;
        A_SF_POS: s_nxt.rdata[NC-1:0] = s_r.sf_pos;
        A_GF_EN:  s_nxt.rdata[NG-1:0] = s_r.gf_en;
        A_GF_POS: s_nxt.rdata[NG-1:0] = s_r.gf_pos;
        A_DIS:    s_nxt.rdata[NG-1:0] = s_r.dis_req;
        A_MODE:   s_nxt.rdata[3:0]    = s_r.mode;
        A_TMO:    s_nxt.rdata[TW-1:0] = s_r.tmo;
        A_STAT:   s_nxt.rdata = {dis_c, s_r.out};
        A_ACT:    s_nxt.rdata[5:0] = {t_run, s_r.dis_act, s_r.gf_act,
                                      s_r.sf_act};
        default:  s_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r      <= '0;
      s_r.mode <= MODE_RST;
      s_r.tmo  <= TMO_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata    = s_r.rdata;
  assign o_contact  = s_r.out;
  assign o_zone_out = s_r.zs[1];
  assign o_supv_out = s_r.zs[0];

  // checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);

  property p_timed_force_ends;
    (t_exp[T_SF] && !t_wr[T_SF] && !s_r.mode[M_SF_PERM])
      |=> !s_r.sf_act ##1 (((o_contact ^ $past(drv)) & ~$past(dis_c)
                            & ~$past(gf_c)) == 0);
  endproperty
  a_timed_force_ends: assert property (p_timed_force_ends)
    else $error("timed single force outlived its timer");

  property p_perm_force_holds;
    (s_r.sf_act && s_r.mode[M_SF_PERM] && !t_wr[T_SF]) |=> s_r.sf_act;
  endproperty
  a_perm_force_holds: assert property (p_perm_force_holds)
    else $error("permanent force dropped without a write");

  property p_single_force_value;
    (sf_c != 0) |=> ((o_contact ^ $past(s_r.sf_pos)) & $past(sf_c)) == 0;
  endproperty
  a_single_force_value: assert property (p_single_force_value)
    else $error("single forced contact not at force position");

  property p_group_wins;
    (gf_c != 0) |=> ((o_contact ^ $past(gpos_c)) & $past(gf_c)) == 0;
  endproperty
  a_group_wins: assert property (p_group_wins)
    else $error("group forced contact not at group position");

  property p_disarm_frozen;
    (dis_c != 0) |=> ((o_contact ^ $past(o_contact)) & $past(dis_c)) == 0;
  endproperty
  a_disarm_frozen: assert property (p_disarm_frozen)
    else $error("disarmed contact switched");

  property p_no_permit_normal;
    1'b1 |=> ((o_contact ^ $past(drv)) & ~$past(perm) & ~$past(dis_c)) == 0;
  endproperty
  a_no_permit_normal: assert property (p_no_permit_normal)
    else $error("contact without permission left normal drive");

  property p_zone_follow;
    1'b1 |=> (o_zone_out == $past(s_r.s2[P_ZONE]))
          && (o_supv_out == $past(s_r.s2[P_SUPV]));
  endproperty
  a_zone_follow: assert property (p_zone_follow)
    else $error("zone or supervision output not following drive");

  property p_timed_disarm_ends;
    (t_exp[T_DIS] && !t_wr[T_DIS] && !s_r.mode[M_DIS_PERM])
      |=> !s_r.dis_act ##1 (dis_c == 0 || $past(t_wr[T_DIS]) || t_wr[T_DIS]
                            || $past(t_wr[T_DIS], 2));
  endproperty
  a_timed_disarm_ends: assert property (p_timed_disarm_ends)
    else $error("timed disarm outlived its timer");

  property p_perm_disarm_holds;
    (s_r.dis_act && s_r.mode[M_DIS_PERM] && !t_wr[T_DIS]) |=> s_r.dis_act;
  endproperty
  a_perm_disarm_holds: assert property (p_perm_disarm_holds)
    else $error("permanent disarm dropped without a write");

  property p_no_disarm_latched;
    1'b1 |=> ((o_contact ^ $past(drv)) & $past(lat | hold)
             & ~$past(gf_c | sf_c)) == 0;
  endproperty
  a_no_disarm_latched: assert property (p_no_disarm_latched)
    else $error("latched or holding contact disarmed");

  property p_disarm_cause;
    1'b1 |=> ((o_contact ^ $past(drv)) & ~$past(gf_c | sf_c)
             & ~($past(dcmd_c) & {NC{$past(s_r.mode[M_DCTL])}})) == 0;
  endproperty
  a_disarm_cause: assert property (p_disarm_cause)
    else $error("disarm without control or direct command");

  property p_tick_period;
    s_r.tick |=> !s_r.tick;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("timebase tick longer than one cycle");

  property p_timed_group_ends;
    (t_exp[T_GF] && !t_wr[T_GF] && !s_r.mode[M_GF_PERM]) |=> !s_r.gf_act;
  endproperty
  a_timed_group_ends: assert property (p_timed_group_ends)
    else $error("timed group force outlived its timer");

  property p_perm_group_holds;
    (s_r.gf_act && s_r.mode[M_GF_PERM] && !t_wr[T_GF]) |=> s_r.gf_act;
  endproperty
  a_perm_group_holds: assert property (p_perm_group_holds)
    else $error("permanent group force dropped without a write");

  property p_force_start;
    (t_wr[T_SF] && t_any[T_SF]) |=> s_r.sf_act && t_run[T_SF];
  endproperty
  a_force_start: assert property (p_force_start)
    else $error("single force write did not start its timer");

  property p_group_start;
    (t_wr[T_GF] && t_any[T_GF]) |=> s_r.gf_act && t_run[T_GF];
  endproperty
  a_group_start: assert property (p_group_start)
    else $error("group force write did not start its timer");

  property p_disarm_start;
    (t_wr[T_DIS] && t_any[T_DIS]) |=> s_r.dis_act && t_run[T_DIS];
  endproperty
  a_disarm_start: assert property (p_disarm_start)
    else $error("disarm write did not start its timer");

  property p_expire_on_tick;
    (t_exp != 0) |-> $past(s_r.tick);
  endproperty
  a_expire_on_tick: assert property (p_expire_on_tick)
    else $error("timer expired without a timebase tick");

  property p_group_disarm_still;
    1'b1 |=> ((o_contact ^ $past(o_contact)) & $past(dreq_c & dcmd_c)
             & ~$past(lat | hold)
             & {NC{$past(s_r.dis_act && s_r.mode[M_DCTL])}}) == 0;
  endproperty
  a_group_disarm_still: assert property (p_group_disarm_still)
    else $error("contact of a disarmed group switched");

  c_group_force: cover property (gf_c != 0 ##1 sf_c == 0);
  c_perm_disarm: cover property (s_r.dis_act && s_r.mode[M_DIS_PERM]
                                 && t_exp[T_DIS]);
  c_latched_skip: cover property (s_r.dis_act && s_r.mode[M_DCTL]
                                  && (lat != 0));
  c_disarm: cover property (dis_c != 0);
  c_timed_expiry: cover property (t_exp[T_SF] && !s_r.mode[M_SF_PERM]);

endmodule
`default_nettype wire

// ==== design/rofd_pkg.sv ====
// constants shared by the relay output force and disarm block
// assumes one 125 MHz core clock and 32-bit register port words
package rofd_pkg;

  // sizes: contacts, groups, contacts per group
  localparam int NC  = 16;
  localparam int NG  = 2;
  localparam int GS  = 8;
  localparam int AW  = 8;
  localparam int TW  = 16;
  localparam int TCW = 17;
  localparam int NT  = 3;

  // timebase
  localparam int CLK_NS   = 8;
  localparam int TICK_NS  = 1000000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;

  // positions in the synchronised pin vector
  localparam int P_DRV  = 0;
  localparam int P_PERM = NC;
  localparam int P_LAT  = 2 * NC;
  localparam int P_HOLD = 3 * NC;
  localparam int P_DCMD = 4 * NC;
  localparam int P_ZONE = 4 * NC + NG;
  localparam int P_SUPV = P_ZONE + 1;
  localparam int PW     = P_SUPV + 1;

  // register byte addresses
  localparam logic [AW-1:0] A_SF_EN  = 8'h00;
  localparam logic [AW-1:0] A_SF_POS = 8'h04;
  localparam logic [AW-1:0] A_GF_EN  = 8'h08;
  localparam logic [AW-1:0] A_GF_POS = 8'h0c;
  localparam logic [AW-1:0] A_DIS    = 8'h10;
  localparam logic [AW-1:0] A_MODE   = 8'h14;
  localparam logic [AW-1:0] A_TMO    = 8'h18;
  localparam logic [AW-1:0] A_STAT   = 8'h1c;
  localparam logic [AW-1:0] A_ACT    = 8'h20;

  // mode register bits
  localparam int M_SF_PERM  = 0;
  localparam int M_GF_PERM  = 1;
  localparam int M_DIS_PERM = 2;
  localparam int M_DCTL     = 3;

  // timer indices
  localparam int T_SF  = 0;
  localparam int T_GF  = 1;
  localparam int T_DIS = 2;

  // reset values
  localparam logic [3:0]    MODE_RST = 4'h0;
  localparam logic [TW-1:0] TMO_RST  = 16'h03e8;

endpackage

// ==== design/rofd_timer.sv ====
// timeout timer counting timebase ticks
// assumes i_tick is a one-cycle pulse on the core clock
`timescale 1ns/1ps
`default_nettype none
module rofd_timer (
  // clock and reset
  input  wire logic                   i_core_clk,
  input  wire logic                   i_reset_n,
  // control
  input  wire logic                   i_start,
  input  wire logic                   i_stop,
  input  wire logic                   i_tick,
  input  wire logic [rofd_pkg::TW-1:0] i_load,
  // status
  output logic                        o_run,
  output logic                        o_expire
);
  import rofd_pkg::*;

  typedef struct packed {
    logic          run;
    logic          expire;
    logic [TW-1:0] cnt;
  } rofd_tmr_t;

  rofd_tmr_t s_r;
  rofd_tmr_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.expire = 1'b0;
    if (i_start) begin
      s_nxt.run = 1'b1;
      s_nxt.cnt = i_load;
    end else if (i_stop) begin
      s_nxt.run = 1'b0;
    end else if (s_r.run && i_tick) begin
      // counts ticks, so the first, partial tick period after a start counts as a whole one
      if (s_r.cnt <= TW'(1)) begin
        s_nxt.run    = 1'b0;
        s_nxt.expire = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_run    = s_r.run;
  assign o_expire = s_r.expire;

endmodule
`default_nettype wire

// ==== sim/rofd_far_model.sv ====
// far side: normal protection logic and contact drivers
// assumes the bench sets the wanted pin levels, all on i_core_clk
`timescale 1ns/1ps
`default_nettype none
module rofd_far_model
  import rofd_pkg::*;
(
  // clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_reset_n,
  // wanted levels
  input  wire logic [NC-1:0] i_req_drive,
  input  wire logic [NC-1:0] i_req_permit,
  input  wire logic [NC-1:0] i_req_latched,
  input  wire logic [NC-1:0] i_req_hold,
  input  wire logic [NG-1:0] i_req_cmd,
  input  wire logic [1:0]    i_req_zs,
  // pins toward the block
  output logic      [NC-1:0] o_normal_drive,
  output logic      [NC-1:0] o_force_permit,
  output logic      [NC-1:0] o_latched,
  output logic      [NC-1:0] o_hold_run,
  output logic      [NG-1:0] o_disarm_cmd,
  output logic               o_zone_drive,
  output logic               o_supv_drive
);
  // pins change only just after a rising edge, or at once when reset is asserted
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_normal_drive <= '0;
      o_force_permit <= '0;
      o_latched      <= '0;
      o_hold_run     <= '0;
      o_disarm_cmd   <= '0;
      o_zone_drive   <= 1'b0;
      o_supv_drive   <= 1'b0;
    end else begin
      o_normal_drive <= i_req_drive;
      o_force_permit <= i_req_permit;
      o_latched      <= i_req_latched;
      o_hold_run     <= i_req_hold;
      o_disarm_cmd   <= i_req_cmd;
      o_zone_drive   <= i_req_zs[1];
      o_supv_drive   <= i_req_zs[0];
    end
  end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// bench for the relay output force and disarm block
// assumes a 4-cycle tick and the far side model on the contact pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rofd_pkg::*;
  logic          i_core_clk = 1'b0;
  logic          i_reset_n  = 1'b0;
  logic [AW-1:0] i_addr     = '0;
  logic [31:0]   i_wdata    = '0;
  logic          i_wr       = 1'b0;
  logic          i_rd       = 1'b0;
  logic [31:0]   o_rdata;
  logic [NC-1:0] req_drive  = '0;
  logic [NC-1:0] req_permit = '1;
  logic [NC-1:0] req_lat    = '0;
  logic [NC-1:0] req_hold   = '0;
  logic [NG-1:0] req_cmd    = '0;
  logic [1:0]    req_zs     = '0;
  logic [NC-1:0] w_drv, w_perm, w_lat, w_hold, o_contact;
  logic [NG-1:0] w_cmd;
  logic          w_zone, w_supv, o_zone_out, o_supv_out;
  int            miscompares  = 0;
  int            total_checks = 0;
  int            cyc          = 0;

  always #4 i_core_clk = ~i_core_clk;

  rofd_far_model i_rofd_far_model (.i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n), .i_req_drive(req_drive),
    .i_req_permit(req_permit), .i_req_latched(req_lat),
    .i_req_hold(req_hold), .i_req_cmd(req_cmd), .i_req_zs(req_zs),
    .o_normal_drive(w_drv), .o_force_permit(w_perm), .o_latched(w_lat),
    .o_hold_run(w_hold), .o_disarm_cmd(w_cmd), .o_zone_drive(w_zone),
    .o_supv_drive(w_supv));

  rofd_force_disarm #(.P_TICK_CYC(4)) i_rofd_force_disarm (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_normal_drive(w_drv), .i_force_permit(w_perm), .i_latched(w_lat),
    .i_hold_run(w_hold), .i_disarm_cmd(w_cmd), .i_zone_drive(w_zone),
    .i_supv_drive(w_supv), .o_contact(o_contact),
    .o_zone_out(o_zone_out), .o_supv_out(o_supv_out));

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rdchk(input logic [AW-1:0] a, input logic [31:0] exp);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1;
    chk(o_rdata, exp);
    @(posedge i_core_clk);
  endtask

  initial begin
    idle(2);
    i_reset_n <= 1'b1;
    rdchk(A_MODE, 32'h0);
    rdchk(A_TMO, {16'h0, TMO_RST});
    rdchk(A_ACT, 32'h0);
    rdchk(8'h24, 32'h0);
    $display("test reset values done");
    req_permit <= 16'hfffe;
    wr(A_TMO, 32'h5);
    wr(A_SF_POS, 32'h00ff);
    wr(A_SF_EN, 32'h0003);
    idle(3);
    rdchk(A_STAT, 32'h2);
    rdchk(A_ACT, 32'h9);
    idle(40);
    rdchk(A_STAT, 32'h0);
    rdchk(A_ACT, 32'h0);
    $display("test timed force done");
    req_permit <= '1;
    wr(A_MODE, 32'h3);
    wr(A_SF_EN, 32'h1);
    idle(40);
    rdchk(A_STAT, 32'h1);
    req_drive <= 16'hffff;
    wr(A_GF_POS, 32'h0);
    wr(A_GF_EN, 32'h1);
    idle(5);
    rdchk(A_STAT, 32'hff00);
    wr(A_GF_EN, 32'h0);
    wr(A_SF_EN, 32'h0);
    idle(5);
    rdchk(A_STAT, 32'hffff);
    $display("test permanent and group force done");
    req_drive <= 16'h00ff;
    req_cmd   <= 2'b01;
    wr(A_MODE, 32'h4);
    wr(A_DIS, 32'h1);
    idle(2);
    req_drive <= 16'h0f0f;
    idle(5);
    rdchk(A_STAT, 32'h0f0f);
    req_drive <= 16'h00ff;
    req_lat   <= 16'h0001;
    req_hold  <= 16'h0002;
    idle(3);
    wr(A_MODE, 32'hc);
    wr(A_DIS, 32'h1);
    idle(5);
    req_drive <= 16'hff00;
    req_zs    <= 2'b11;
    wr(A_MODE, 32'hd);
    wr(A_SF_POS, 32'h0);
    wr(A_SF_EN, 32'h4);
    idle(5);
    rdchk(A_STAT, 32'h00fcfffc);
    chk({31'h0, o_zone_out}, 32'h1);
    chk({31'h0, o_supv_out}, 32'h1);
    idle(40);
    rdchk(A_STAT, 32'h00fcfffc);
    req_drive <= 16'hffff;
    wr(A_DIS, 32'h0);
    idle(5);
    rdchk(A_STAT, 32'h0000fffb);
    $display("test permanent disarm done");
    wr(A_SF_EN, 32'h0);
    req_lat   <= '0;
    req_hold  <= '0;
    req_drive <= 16'h00ff;
    wr(A_MODE, 32'h8);
    wr(A_TMO, 32'h8);
    wr(A_DIS, 32'h1);
    idle(4);
    req_drive <= 16'h0000;
    idle(5);
    rdchk(A_STAT, 32'h00ff00ff);
    idle(40);
    rdchk(A_STAT, 32'h0);
    $display("test timed disarm done");
    wr(A_MODE, 32'h0);
    wr(A_TMO, 32'h4);
    wr(A_GF_POS, 32'h2);
    wr(A_GF_EN, 32'h2);
    idle(3);
    rdchk(A_STAT, 32'h0000ff00);
    idle(20);
    rdchk(A_STAT, 32'h0);
    $display("test timed group force done");
    end_of_test();
  end
endmodule
`default_nettype wire
